/* File: hss_axis_model.sv */
module hss_axis_model (
  input  wire logic               clock,       // System clock.
  input  wire logic               load,        // Place the axis at load_pos.
  input  wire logic signed [31:0] load_pos,    // Position to place the axis at.
  input  wire logic signed [31:0] home_lo,     // Lower edge of the home section.
  input  wire logic signed [31:0] home_hi,     // Upper edge of the home section.
  input  wire logic signed [31:0] lim_neg,     // Minus limit active at or below.
  input  wire logic signed [31:0] lim_pos,     // Plus limit active at or above.
  input  wire logic               lim_mode,    // Sensors fed by the minus limit.
  input  wire logic [3:0]         lvl,         // Active levels: near, home, index, limit.
  input  wire logic               drive_pulse, // Step pulse from the sequencer.
  input  wire logic               drive_dir,   // 1 = plus direction.
  output logic                    near_n,      // Near-home pin.
  output logic                    home_n,      // Home pin.
  output logic                    index_n,     // Encoder index pin.
  output logic                    plus_lim,    // Plus limit pin.
  output logic                    minus_lim,   // Minus limit pin.
  output logic signed [31:0]      pos          // Mechanical position in pulses.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic in_home;
  logic at_neg;
  logic at_pos;
  // The axis moves one pulse per step in the commanded direction.
  always_ff @(posedge clock) begin
    if (load) pos <= load_pos;
    else if (drive_pulse) pos <= drive_dir ? pos + 1 : pos - 1;
  end
  // Limit sections reach the mechanical ends, so a decelerating stop ends inside them.
  assign at_neg = (pos <= lim_neg);
  assign at_pos = (pos >= lim_pos);
  assign in_home = lim_mode ? at_neg : (pos >= home_lo && pos <= home_hi);
  // One switch feeds both near-home and home pins, so they share the section; each pin has its own level bit.
  assign near_n = in_home ? lvl[0] : ~lvl[0];
  assign home_n = in_home ? lvl[1] : ~lvl[1];
  // The index mark sits five pulses above the upper edge of the home section.
  assign index_n = (pos == home_hi + 32'sd5) ? lvl[2] : ~lvl[2];
  assign minus_lim = at_neg ? lvl[3] : ~lvl[3];
  assign plus_lim = at_pos ? lvl[3] : ~lvl[3];
endmodule

/* File: hss_home_search.sv */
// Contract
// - Step one: high speed, decelerating stop on near-home.
// - Stopped inside home: escape, then low-speed search.
// - Overshoot: run to limit, then third recovery.
// - Home active at start: skip step one.
// - Step one hits limit: second recovery.
// - Step four drives configured offset at high speed.
// - Position clear after sequence when enabled.
// - Limit mode step one: stop on limit.
// - Limit mode step two: leave, re-approach slowly.
// - Limit active at start: begin step two.
// - Limit mode offset leaves limit section.
// - Disabled step skipped immediately.
// - Inputs active low or open per setting.
//
// The Wishbone register port and the placing of the registers were left to the implementer.
module hss_home_search (
  input  wire logic        clock,                 // System clock, 250 MHz.
  input  wire logic        rstn,                  // Synchronous reset, active low.
  input  wire logic        wb_cyc_i,              // Wishbone cycle.
  input  wire logic        wb_stb_i,              // Wishbone strobe.
  input  wire logic        wb_we_i,               // Wishbone write enable.
  input  wire logic [7:0]  wb_adr_i,              // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,              // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,              // Wishbone write data.
  output logic      [31:0] wb_dat_o,              // Wishbone read data.
  output logic             wb_ack_o,              // Wishbone acknowledge.
  input  wire logic        near_home_input_n,     // Near-home sensor pin.
  input  wire logic        home_input_n,          // Home sensor pin.
  input  wire logic        index_input_n,         // Encoder index pin.
  input  wire logic        positive_travel_limit, // Plus limit pin level.
  input  wire logic        negative_travel_limit, // Minus limit pin level.
  output logic             drive_pulse,           // One-cycle drive pulse.
  output logic             drive_dir,             // 1 = plus direction.
  output logic             busy                   // Search in progress.
);

  logic [31:0]            ctrl_reg;
  logic [31:0]            hi_per_reg;
  logic [31:0]            lo_per_reg;
  logic [31:0]            offset_reg;
  logic [31:0]            decel_reg;
  logic [31:0]            pos_reg;
  logic [31:0]            cnt_reg;
  logic                   seen_reg;
  logic                   start;
  logic                   tick;
  logic                   moving;
  logic                   dir_now;
  logic                   fast;
  logic                   wb_req;
  logic [31:0]            wmask;
  hss_pkg::hss_state_e    st_reg;
  hss_pkg::hss_state_e    st_next;
  hss_pkg::hss_cfg_s      cfg;

  // Search configuration fields out of the control register.
  assign cfg.en        = ctrl_reg[hss_pkg::EN_LSB +: 4];
  assign cfg.dir       = ctrl_reg[hss_pkg::DIR_LSB +: 4];
  assign cfg.near_lvl  = ctrl_reg[hss_pkg::NEAR_LVL];
  assign cfg.home_lvl  = ctrl_reg[hss_pkg::HOME_LVL];
  assign cfg.index_lvl = ctrl_reg[hss_pkg::INDEX_LVL];
  assign cfg.limit_lvl = ctrl_reg[hss_pkg::LIMIT_LVL];
  assign cfg.pos_clr   = ctrl_reg[hss_pkg::POSCLR_BIT];
  assign cfg.use_limit = ctrl_reg[hss_pkg::USELIM_BIT];

  // A pin is active when its level equals the configured level.
  function automatic logic active(input logic pin, input logic lvl);
    return pin == lvl;
  endfunction

  // Limit in a given direction is active.
  function automatic logic lim_in(input logic d, input hss_pkg::hss_cfg_s c,
                                  input logic lp, input logic ln);
    return d ? active(lp, c.limit_lvl) : active(ln, c.limit_lvl);
  endfunction

  logic near_act;
  logic home_act;
  logic idx_act;
  logic lim1;
  logic lim2;
  logic det1;
  logic det2;
  assign near_act = active(near_home_input_n, cfg.near_lvl);
  assign home_act = active(home_input_n, cfg.home_lvl);
  assign idx_act  = active(index_input_n, cfg.index_lvl);
  assign lim1     = lim_in(cfg.dir[0], cfg, positive_travel_limit, negative_travel_limit);
  assign lim2     = lim_in(cfg.dir[1], cfg, positive_travel_limit, negative_travel_limit);
  // In limit mode the limit itself is the detection signal.
  assign det1     = cfg.use_limit ? lim1 : near_act;
  assign det2     = cfg.use_limit ? lim2 : home_act;

  // Entry to the first enabled step at or after step k; disabled steps, step one while d2 is set and step four with a zero offset are skipped.
  function automatic hss_pkg::hss_state_e enter(input int k, input hss_pkg::hss_cfg_s c,
                                                input logic d2, input logic zero_off);
    if (k <= 1 && c.en[0] && !d2)
      return hss_pkg::ST_S1;
    if (k <= 2 && c.en[1])
      return d2 ? hss_pkg::ST_ESC : hss_pkg::ST_S2;
    if (k <= 3 && c.en[2])
      return hss_pkg::ST_S3;
    if (k <= 4 && c.en[3] && !zero_off)
      return hss_pkg::ST_S4;
    return hss_pkg::ST_CLR;
  endfunction

  logic [31:0] off_abs;
  logic        off_zero;
  assign off_abs  = offset_reg[31] ? 32'(-offset_reg) : offset_reg;
  assign off_zero = offset_reg == 32'h0000_0000;

  // Wishbone request and write-mask from byte selects.
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  generate
    for (genvar b = 0; b < 4; b++) begin : g_mask
      assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
    end
  endgenerate
  assign start = wb_req && wb_we_i && wb_adr_i == hss_pkg::CTRL_OFS
                 && wb_sel_i[0] && wb_dat_i[hss_pkg::START_BIT] && st_reg == hss_pkg::ST_IDLE;

  // Acknowledge one cycle after the request; unmapped reads return zero.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          hss_pkg::CTRL_OFS:   wb_dat_o <= ctrl_reg;
          hss_pkg::HI_PER_OFS: wb_dat_o <= hi_per_reg;
          hss_pkg::LO_PER_OFS: wb_dat_o <= lo_per_reg;
          hss_pkg::OFFSET_OFS: wb_dat_o <= offset_reg;
          hss_pkg::DECEL_OFS:  wb_dat_o <= decel_reg;
          hss_pkg::STATUS_OFS: wb_dat_o <= {23'h000000, st_reg};
          hss_pkg::POS_OFS:    wb_dat_o <= pos_reg;
          default:             wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration registers; the start bit is a strobe and never stored.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_reg   <= hss_pkg::CTRL_RST;
      hi_per_reg <= hss_pkg::HI_PER_RST;
      lo_per_reg <= hss_pkg::LO_PER_RST;
      offset_reg <= hss_pkg::OFFSET_RST;
      decel_reg  <= hss_pkg::DECEL_RST;
    end else if (wb_req && wb_we_i) begin
      unique case (wb_adr_i)
        hss_pkg::CTRL_OFS:   ctrl_reg   <= ((ctrl_reg & ~wmask) | (wb_dat_i & wmask)) & ~32'h0000_0001;
        hss_pkg::HI_PER_OFS: hi_per_reg <= (hi_per_reg & ~wmask) | (wb_dat_i & wmask);
        hss_pkg::LO_PER_OFS: lo_per_reg <= (lo_per_reg & ~wmask) | (wb_dat_i & wmask);
        hss_pkg::OFFSET_OFS: offset_reg <= (offset_reg & ~wmask) | (wb_dat_i & wmask);
        hss_pkg::DECEL_OFS:  decel_reg  <= (decel_reg & ~wmask) | (wb_dat_i & wmask);
        default:             ;
      endcase
    end
  end

  // Direction and speed of the running move in each state.
  always_comb begin
    moving  = 1'b1;
    fast    = 1'b0;
    dir_now = cfg.dir[1];
    unique case (st_reg)
      hss_pkg::ST_S1, hss_pkg::ST_S1DEC: begin
        fast    = 1'b1;
        dir_now = cfg.dir[0];
      end
      hss_pkg::ST_ESC:   dir_now = ~cfg.dir[1];
      hss_pkg::ST_S2:    dir_now = cfg.dir[1];
      hss_pkg::ST_TOLIM: dir_now = cfg.dir[1];
      hss_pkg::ST_S3:    dir_now = cfg.dir[2];
      hss_pkg::ST_S4: begin
        fast    = 1'b1;
        dir_now = cfg.dir[3] ^ offset_reg[31];
      end
      default:           moving = 1'b0;
    endcase
  end

  // Step-rate generator for the running move.
  hss_rate_gen #(.W(32)) u_rate (
    .clock  (clock),
    .rstn   (rstn),
    .run    (moving),
    .period (fast ? hi_per_reg : lo_per_reg),
    .tick   (tick)
  );

  // Next-state logic of the search sequence.
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      hss_pkg::ST_IDLE:
        if (start)
          st_next = enter(1, cfg, det2, off_zero);
      hss_pkg::ST_S1:
        if (det1 || lim1)
          st_next = hss_pkg::ST_S1DEC;
      hss_pkg::ST_S1DEC:
        if (cnt_reg == 32'h0000_0000) begin
          if (det2 || lim1 || !cfg.en[1])
            st_next = enter(2, cfg, cfg.en[1] ? 1'b1 : det2, off_zero);
          else
            st_next = hss_pkg::ST_TOLIM;
        end
      hss_pkg::ST_ESC:
        if (seen_reg && !det2)
          st_next = hss_pkg::ST_S2;
      hss_pkg::ST_S2:
        if (det2)
          st_next = enter(3, cfg, det2, off_zero);
        else if (lim2)
          st_next = hss_pkg::ST_ESC;
      hss_pkg::ST_TOLIM:
        if (lim2)
          st_next = hss_pkg::ST_ESC;
      hss_pkg::ST_S3:
        if (idx_act)
          st_next = enter(4, cfg, det2, off_zero);
      hss_pkg::ST_S4:
        if (cnt_reg == 32'h0000_0000)
          st_next = hss_pkg::ST_CLR;
      hss_pkg::ST_CLR:
        st_next = hss_pkg::ST_IDLE;
    endcase
  end

  // State register and the pass marker of the escape move.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_reg   <= hss_pkg::ST_IDLE;
      seen_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (st_next == hss_pkg::ST_ESC && st_reg != hss_pkg::ST_ESC)
        seen_reg <= det2;
      else if (det2)
        seen_reg <= 1'b1;
    end
  end

  // Pulse counter for deceleration and offset moves.
  always_ff @(posedge clock) begin
    if (!rstn)
      cnt_reg <= 32'h0000_0000;
    else if (st_next == hss_pkg::ST_S1DEC && st_reg != hss_pkg::ST_S1DEC)
      cnt_reg <= decel_reg;
    else if (st_next == hss_pkg::ST_S4 && st_reg != hss_pkg::ST_S4)
      cnt_reg <= off_abs;
    else if (tick && cnt_reg != 32'h0000_0000)
      cnt_reg <= cnt_reg - 32'h0000_0001;
  end

  // Drive outputs and position counter.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      drive_pulse <= 1'b0;
      drive_dir   <= 1'b0;
      pos_reg     <= 32'h0000_0000;
    end else begin
      drive_pulse <= tick && moving;
      drive_dir   <= moving ? dir_now : drive_dir;
      if (st_reg == hss_pkg::ST_CLR && cfg.pos_clr)
        pos_reg <= 32'h0000_0000;
      else if (tick && moving)
        pos_reg <= dir_now ? pos_reg + 32'h0000_0001 : pos_reg - 32'h0000_0001;
    end
  end

  // Busy flag covers all steps and the final clear.
  always_ff @(posedge clock) begin
    if (!rstn)
      busy <= 1'b0;
    else
      busy <= st_next != hss_pkg::ST_IDLE;
  end

  property p_busy;
    @(posedge clock) disable iff (!rstn)
    (st_reg != hss_pkg::ST_IDLE) |-> busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy low while searching");

  property p_s1_detect;
    @(posedge clock) disable iff (!rstn)
    (st_reg == hss_pkg::ST_S1 && det1) |=> (st_reg == hss_pkg::ST_S1DEC);
  endproperty
  a_s1_detect: assert property (p_s1_detect) else $error("step one ignored detection");

  property p_skip_s1;
    @(posedge clock) disable iff (!rstn)
    (st_reg == hss_pkg::ST_IDLE && start && det2 && cfg.en[1]) |=> (st_reg == hss_pkg::ST_ESC);
  endproperty
  a_skip_s1: assert property (p_skip_s1) else $error("start inside section not escaped");

  property p_esc_dir;
    @(posedge clock) disable iff (!rstn)
    (st_reg == hss_pkg::ST_ESC && tick) |=> (drive_pulse && drive_dir == ~cfg.dir[1]);
  endproperty
  a_esc_dir: assert property (p_esc_dir) else $error("escape move in wrong direction");

  property p_tolim;
    @(posedge clock) disable iff (!rstn)
    (st_reg == hss_pkg::ST_TOLIM && lim2) |=> (st_reg == hss_pkg::ST_ESC);
  endproperty
  a_tolim: assert property (p_tolim) else $error("limit not followed by recovery");

  property p_clear;
    @(posedge clock) disable iff (!rstn)
    (st_reg == hss_pkg::ST_CLR && cfg.pos_clr) |=> (pos_reg == 32'h0000_0000 && !busy);
  endproperty
  a_clear: assert property (p_clear) else $error("position not cleared at end");

  property p_s4_dir;
    @(posedge clock) disable iff (!rstn)
    (st_reg == hss_pkg::ST_S4 && tick) |=> (drive_dir == (cfg.dir[3] ^ offset_reg[31]));
  endproperty
  a_s4_dir: assert property (p_s4_dir) else $error("offset move in wrong direction");

  property p_skip_disabled;
    @(posedge clock) disable iff (!rstn)
    (st_reg == hss_pkg::ST_IDLE && start && cfg.en == 4'h0) |=> (st_reg == hss_pkg::ST_CLR);
  endproperty
  a_skip_disabled: assert property (p_skip_disabled) else $error("disabled step was run");

  property p_ack;
    @(posedge clock) disable iff (!rstn)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus acknowledge not one cycle");

endmodule

/* File: hss_pkg.sv */
package hss_pkg;

  // Wishbone register offsets (byte addresses).
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] HI_PER_OFS  = 8'h04;
  localparam logic [7:0] LO_PER_OFS  = 8'h08;
  localparam logic [7:0] OFFSET_OFS  = 8'h0c;
  localparam logic [7:0] DECEL_OFS   = 8'h10;
  localparam logic [7:0] STATUS_OFS  = 8'h14;
  localparam logic [7:0] POS_OFS     = 8'h18;

  // Control register field positions.
  localparam int START_BIT  = 0;
  localparam int EN_LSB     = 1;
  localparam int DIR_LSB    = 5;
  localparam int NEAR_LVL   = 9;
  localparam int HOME_LVL   = 10;
  localparam int INDEX_LVL  = 11;
  localparam int LIMIT_LVL  = 12;
  localparam int POSCLR_BIT = 13;
  localparam int USELIM_BIT = 14;

  // Control reset value: steps 1..4 disabled, steps 1,2 minus, 3,4 plus,
  // all levels low-active, position clear on, limit search off.
  localparam logic [31:0] CTRL_RST = 32'h0000_2180;

  // Timing: clock rate and documented search speeds.
  localparam int CLK_HZ     = 250_000_000;
  localparam int HI_PPS     = 20_000;
  localparam int LO_PPS     = 200;
  localparam logic [31:0] HI_PER_RST = 32'(CLK_HZ / HI_PPS);
  localparam logic [31:0] LO_PER_RST = 32'(CLK_HZ / LO_PPS);
  localparam logic [31:0] OFFSET_RST = 32'h0000_0dac;
  localparam logic [31:0] DECEL_RST  = 32'h0000_0010;

  // Sequencer states, one-hot.
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_S1    = 9'h002,
    ST_S1DEC = 9'h004,
    ST_ESC   = 9'h008,
    ST_S2    = 9'h010,
    ST_TOLIM = 9'h020,
    ST_S3    = 9'h040,
    ST_S4    = 9'h080,
    ST_CLR   = 9'h100
  } hss_state_e;

  // Decoded search configuration.
  typedef struct packed {
    logic [3:0] en;
    logic [3:0] dir;      // 1 = plus direction.
    logic       near_lvl; // 1 = active when open.
    logic       home_lvl;
    logic       index_lvl;
    logic       limit_lvl;
    logic       pos_clr;
    logic       use_limit;
  } hss_cfg_s;

endpackage

/* File: hss_rate_gen.sv */
module hss_rate_gen #(
  parameter int W = 32
) (
  input  wire logic         clock,  // System clock.
  input  wire logic         rstn,   // Synchronous reset, active low.
  input  wire logic         run,    // Produce ticks while high.
  input  wire logic [W-1:0] period, // Clocks between ticks.
  output logic              tick    // One-cycle tick.
);

  logic [W-1:0] cnt_reg;

  // Counts up a full period, then ticks; restarts whenever run drops.
  always_ff @(posedge clock) begin
    if (!rstn || !run) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (cnt_reg + W'(1) >= period) begin
      cnt_reg <= '0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + W'(1);
      tick    <= 1'b0;
    end
  end

endmodule

/* File: testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn, wb_cyc, wb_stb, wb_we, wb_ack, m_load, m_mode, first_dir;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel, m_lvl;
  logic [31:0] wb_dat, wb_dat_o, rng, rd;
  logic near_n, home_n, index_n, plim, nlim, drive_pulse, drive_dir, busy;
  logic signed [31:0] pos_w;
  int errors, tests_run, stray, cnt_model, min_pos, seen, off, m_pos, m_lo, m_hi;
  logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  logic [31:0] rst [8] = '{hss_pkg::CTRL_RST, hss_pkg::HI_PER_RST, hss_pkg::LO_PER_RST,
                           hss_pkg::OFFSET_RST, hss_pkg::DECEL_RST, 32'h1, 32'h0, 32'h0};

  hss_home_search dut_u (.clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack), .near_home_input_n(near_n), .home_input_n(home_n), .index_input_n(index_n),
    .positive_travel_limit(plim), .negative_travel_limit(nlim), .drive_pulse(drive_pulse),
    .drive_dir(drive_dir), .busy(busy));

  hss_axis_model axis_u (.clock(clock), .load(m_load), .load_pos(m_pos), .home_lo(m_lo), .home_hi(m_hi),
    .lim_neg(-32'sd60), .lim_pos(32'sd400), .lim_mode(m_mode), .lvl(m_lvl), .drive_pulse(drive_pulse),
    .drive_dir(drive_dir), .near_n(near_n), .home_n(home_n), .index_n(index_n), .plus_lim(plim),
    .minus_lim(nlim), .pos(pos_w));

  // Free-running system clock.
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pos(input string nm, input logic signed [31:0] e, input logic signed [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  // One classic bus cycle; the request holds until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clock);
    wb_cyc <= 1;
    wb_stb <= 1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= s;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc <= 0;
    wb_stb <= 0;
    wb_we <= 0;
    if (n >= 50) chk_bit("wb ack", 1'b1, wb_ack);
  endtask

  // Places the axis, starts a search, waits for the end and compares with the model.
  task automatic run(input string nm, input logic [14:0] cf, input int start, input int exp_pos, input int exp_dir);
    int n;
    @(posedge clock);
    m_pos <= start;
    m_load <= 1;
    @(posedge clock);
    m_load <= 0;
    seen = 0;
    min_pos = start;
    // The start strobe acts on the stored setup, so the setup is written first.
    wb(1, hss_pkg::CTRL_OFS, {17'h0, cf[14:1], 1'b0}, 4'hf);
    wb(1, hss_pkg::CTRL_OFS, {17'h0, cf}, 4'hf);
    #1;
    if (cf[4:1] != 4'h0) chk_bit("busy after start", 1'b1, busy);
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    chk_pos("final position", exp_pos, pos_w);
    if (exp_dir >= 0) chk_bit("first direction", exp_dir[0], first_dir);
    cnt_model = cf[13] ? 0 : cnt_model + exp_pos - start;
    wb(0, hss_pkg::POS_OFS, 32'h0, 4'hf);
    chk_reg("position count", cnt_model, rd);
    wb(0, hss_pkg::STATUS_OFS, 32'h0, 4'hf);
    chk_reg("status idle", 32'h1, rd);
    chk_pos("pulses while idle", 0, stray);
    $display("test %s done", nm);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watches every drive pulse for busy, first direction and the deepest travel.
  always @(posedge clock) begin
    if (rstn && drive_pulse === 1'b1) begin
      if (busy !== 1'b1) stray++;
      if (seen == 0) first_dir = drive_dir;
      seen = 1;
      if (pos_w < min_pos) min_pos = pos_w;
    end
  end

  // Cuts a hang short.
  initial begin
    repeat (90000) @(posedge clock);
    chk_bit("watchdog", 1'b1, 1'b0);
    stop_test;
  end

  initial begin
    rstn = 0; wb_cyc = 0; wb_stb = 0; wb_we = 0; wb_adr = 8'h00; wb_sel = 4'h0; wb_dat = 32'h0;
    m_load = 1; m_pos = 0; m_lo = -20; m_hi = 20; m_mode = 0; m_lvl = 4'h0;
    errors = 0; tests_run = 0; stray = 0; cnt_model = 0; rng = 32'h77e5b7dd;
    repeat (3) @(posedge clock);
    rstn <= 1;
    foreach (ofs[i]) begin
      wb(0, ofs[i], 32'h0, 4'hf);
      chk_reg("reset value", rst[i], rd);
    end
    rng = xs(rng);
    wb(1, hss_pkg::HI_PER_OFS, rng, 4'b0101);
    wb(0, hss_pkg::HI_PER_OFS, 32'h0, 4'hf);
    chk_reg("byte lanes", (hss_pkg::HI_PER_RST & 32'hff00ff00) | (rng & 32'h00ff00ff), rd);
    $display("test registers done");
    wb(1, hss_pkg::HI_PER_OFS, 32'h4, 4'hf);
    wb(1, hss_pkg::LO_PER_OFS, 32'h8, 4'hf);
    wb(1, hss_pkg::DECEL_OFS, 32'h3, 4'hf);
    rng = xs(rng);
    off = 20 + int'(rng[4:0]);
    wb(1, hss_pkg::OFFSET_OFS, 32'(off), 4'hf);
    run("home outside", 15'h2117, 100 + int'(rng[10:5]), 20 + off, 0);
    run("home at start", 15'h2117, 0, 20 + off, 1);
    run("index search", 15'h219f, 100, 25 + off, 0);
    run("limit in step one", 15'h2117, -30, 20 + off, 0);
    chk_bit("limit reached", 1'b1, logic'(min_pos <= -60));
    m_lo <= -1;
    m_hi <= 1;
    wb(1, hss_pkg::DECEL_OFS, 32'ha, 4'hf);
    run("overshoot", 15'h2117, 100, 1 + off, 0);
    chk_bit("limit reached", 1'b1, logic'(min_pos <= -60));
    m_lo <= -20;
    m_hi <= 20;
    m_lvl <= 4'hf;
    wb(1, hss_pkg::DECEL_OFS, 32'h3, 4'hf);
    run("levels high", 15'h1f17, 150, 20 + off, 0);
    m_lvl <= 4'h0;
    m_mode <= 1;
    run("limit search", 15'h6117, 0, -60 + off, 0);
    run("limit at start", 15'h6117, -62, -60 + off, 1);
    m_mode <= 0;
    wb(1, hss_pkg::OFFSET_OFS, 32'(-off), 4'hf);
    run("offset only", 15'h2111, 50, 50 - off, 0);
    run("no steps", 15'h2101, 50, 50, -1);
    stop_test;
  end
endmodule
